// *** core/imusc_pkg.sv ***
// Shared constants, types and the register map of the sample clock and processing core.
// Assumes one 250 MHz system clock and a plain register port driven by a local master.
package imusc_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int INT_RATE_HZ = 2000;
   localparam int INT_DIV_CYC = 1_000_000_000 / (CLK_PERIOD_NS * INT_RATE_HZ);
   localparam int LOCK_WIN_US = 100;
   localparam int LOCK_WIN_CYC = (LOCK_WIN_US * 1000) / CLK_PERIOD_NS;
   localparam int RB_DELAY_US = 200;
   localparam int RB_DELAY_CYC = (RB_DELAY_US * 1000) / CLK_PERIOD_NS;
   localparam int DR_PULSE_NS = 1000;
   localparam int DR_PULSE_CYC = (DR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SYNC_PULSE_NS = 1000;
   localparam int SYNC_PULSE_CYC = (SYNC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Register addresses
   localparam logic [7:0] ADDR_MISC = 8'h00;
   localparam logic [7:0] ADDR_SCALE = 8'h01;
   localparam logic [7:0] ADDR_FIR = 8'h02;
   localparam logic [7:0] ADDR_DEC = 8'h03;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_OUT_BASE = 8'h08;
   localparam logic [7:0] ADDR_COUNT = 8'h0e;

   // ==========================================================
   // Field positions and reset values
   localparam int MISC_POL_BIT = 0;
   localparam int MISC_MODE_LSB = 2;
   localparam int MISC_PP_BIT = 6;
   localparam int MISC_LA_BIT = 7;
   localparam int MISC_RB_LSB = 6;
   localparam logic [15:0] MISC_RST = 16'h00c1;
   localparam logic [15:0] SCALE_RST = 16'h07d0;
   localparam logic [15:0] FIR_RST = 16'h0000;
   localparam logic [15:0] DEC_RST = 16'h0000;
   localparam int CAL_FRAC = 14;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      MODE_INTERNAL = 2'b00,
      MODE_DIRECT = 2'b01,
      MODE_SCALED = 2'b10,
      MODE_OUTPUT = 2'b11
   } imusc_mode_e;
   typedef logic [2:0][15:0] imusc_vec_t;
   typedef logic [8:0][15:0] imusc_mat_t;
   typedef struct packed {
      imusc_vec_t gyro;
      imusc_vec_t accel;
   } imusc_raw_s;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } imusc_req_s;

   // ==========================================================
   // Factory coefficients, Q2.14, element index is row*3+column
   localparam imusc_mat_t GYRO_SCALE = {16'h4000, 16'h0000, 16'h0000, 16'h0000, 16'h4000,
                                        16'h0000, 16'h0000, 16'h0000, 16'h4000};
   localparam imusc_vec_t GYRO_BIAS = {16'h0000, 16'h0000, 16'h0000};
   localparam imusc_mat_t GYRO_LA = {16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0040,
                                     16'h0000, 16'h0000, 16'h0000, 16'h0040};
   localparam imusc_mat_t ACCEL_SCALE = GYRO_SCALE;
   localparam imusc_vec_t ACCEL_BIAS = {16'h0000, 16'h0000, 16'h0000};
   localparam imusc_mat_t ACCEL_PP = {16'h0000, 16'h0040, 16'h0040, 16'h0040, 16'h0000,
                                      16'h0040, 16'h0040, 16'h0040, 16'h0000};

endpackage : imusc_pkg

// *** core/imusc_core.sv ***
// Sample clock selection, scaled-sync PLL, calibration, FIR and decimation of an IMU core.
// Assumes a same-clock register master and a sensor front end that always presents the
// latest raw sample; the sync pin is asynchronous and is resynchronised here.
//
// Design decisions made here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
module imusc_core import imusc_pkg::*; #(
   parameter int INT_DIV = INT_DIV_CYC,
   parameter int LOCK_CYC = LOCK_WIN_CYC,
   parameter int RB_DELAY = RB_DELAY_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input imusc_req_s reg_req,
   output logic [15:0] reg_rdata,
   input imusc_raw_s sensor_raw,
   output logic sample_clock,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe,
   output logic data_ready
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [15:0] misc;
      logic [1:0] mode_rb;
      logic [15:0] scale;
      logic [15:0] scale_rb;
      logic cfg_pend;
      logic [3:0] cal_rb;
      logic [16:0] rb_cnt;
      logic [15:0] fir;
      logic [15:0] dec;
      logic sync_q1;
      logic sync_q2;
      logic sync_q3;
      logic [16:0] int_cnt;
      logic [27:0] per_cnt;
      logic [27:0] period;
      logic [28:0] phase;
      logic [15:0] fb_cnt;
      logic [27:0] since_fb;
      logic have_per;
      logic locked;
      logic tick;
      logic [7:0] spulse_cnt;
      logic sync_out;
      logic sync_oe;
      logic [7:0] dr_cnt;
      logic dr_act;
      logic dr;
      imusc_vec_t gyro_cal;
      imusc_vec_t accel_cal;
      logic [5:0][7:0][15:0] hist1;
      logic [5:0][7:0][15:0] hist2;
      logic [15:0] dec_cnt;
      logic [5:0][31:0] acc;
      logic [5:0][15:0] out;
      logic [15:0] data_cnt;
      logic [15:0] rdata;
   } imusc_state_s;

   imusc_state_s s;
   imusc_state_s next_s;

   // ==========================================================
   // Arithmetic helpers
   // One row of a 3x3 matrix times a vector, full width so nothing wraps
   function automatic logic signed [35:0] mac3(imusc_mat_t m, int row, imusc_vec_t v);
      logic signed [35:0] sum;
      sum = '0;
      for (int j = 0; j < 3; j++) begin
         sum = sum + 36'($signed(m[row * 3 + j])) * 36'($signed(v[j]));
      end
      return sum;
   endfunction : mac3

   // Clip a wide fixed-point result back to a 16-bit sample
   function automatic logic [15:0] sat16(logic signed [35:0] v);
      if (v > 36'sh0_0000_7fff) begin
         return 16'h7fff;
      end else if (v < -36'sh0_0000_8000) begin
         return 16'h8000;
      end
      return v[15:0];
   endfunction : sat16

   // Mean of the newest 2^k history entries; power-of-two taps avoid a divider
   function automatic logic [15:0] win_avg(logic [7:0][15:0] h, logic [1:0] k);
      logic signed [18:0] sum;
      sum = '0;
      for (int i = 0; i < 8; i++) begin
         if (i < (1 << k)) begin
            sum = sum + 19'($signed(h[i]));
         end
      end
      return 16'(sum >>> k);
   endfunction : win_avg

   // ==========================================================
   // Next-state logic
   always_comb begin
      imusc_mode_e mode;
      logic ref_edge;
      logic int_tick;
      logic pll_tick;
      logic pll_clear;
      logic update;
      logic [28:0] phase_sum;
      logic signed [35:0] wide;
      imusc_vec_t gyro_new;
      imusc_vec_t accel_new;
      imusc_vec_t gyro_sq;
      logic signed [31:0] sq;
      logic [5:0][15:0] cal6;
      logic [15:0] f1;
      logic [15:0] f2;
      logic signed [32:0] divisor;
      logic signed [32:0] quot;
      mode = imusc_mode_e'(s.misc[MISC_MODE_LSB +: 2]);
      ref_edge = 1'b0;
      int_tick = 1'b0;
      pll_tick = 1'b0;
      pll_clear = 1'b0;
      update = 1'b0;
      phase_sum = '0;
      wide = '0;
      gyro_new = '0;
      accel_new = '0;
      gyro_sq = '0;
      sq = '0;
      cal6 = '0;
      f1 = '0;
      f2 = '0;
      divisor = '0;
      quot = '0;
      next_s = s;
      next_s.tick = 1'b0;
      next_s.rdata = '0;

      // Two-flop synchroniser, edge taken from the second and third stages
      next_s.sync_q1 = sync_in;
      next_s.sync_q2 = s.sync_q1;
      next_s.sync_q3 = s.sync_q2;
      ref_edge = s.sync_q2 & ~s.sync_q3;

      if (s.int_cnt == '0) begin
         next_s.int_cnt = 17'(INT_DIV - 1);
         int_tick = 1'b1;
      end else begin
         next_s.int_cnt = s.int_cnt - 17'd1;
      end

      // factor change or leaving scaled mode restarts locking
      pll_clear = (mode != MODE_SCALED) ||
                  (reg_req.wr && reg_req.addr == ADDR_SCALE && reg_req.wdata != s.scale);
      // phase accumulator adds K per cycle against the measured period
      if (s.per_cnt != 28'hfff_ffff) begin
         next_s.per_cnt = s.per_cnt + 28'd1;
      end
      if (s.since_fb != 28'hfff_ffff) begin
         next_s.since_fb = s.since_fb + 28'd1;
      end
      phase_sum = s.phase + 29'(s.scale);
      if (s.have_per && s.fb_cnt < s.scale) begin
         if (phase_sum >= 29'(s.period)) begin
            next_s.phase = phase_sum - 29'(s.period);
            pll_tick = 1'b1;
            next_s.fb_cnt = s.fb_cnt + 16'd1;
            // Feedback edge is the K-th generated sample
            if (s.fb_cnt + 16'd1 == s.scale) begin
               next_s.since_fb = '0;
            end
         end else begin
            next_s.phase = phase_sum;
         end
      end
      // reference edge judges lock, then resets the feedback edge
      if (ref_edge) begin
         if (s.have_per) begin
            next_s.locked = (s.fb_cnt == s.scale) && (s.since_fb <= 28'(LOCK_CYC));
         end
         next_s.period = s.per_cnt;
         next_s.have_per = 1'b1;
         next_s.per_cnt = '0;
         next_s.phase = '0;
         next_s.fb_cnt = '0;
      end
      if (pll_clear) begin
         next_s.locked = 1'b0;
         next_s.have_per = 1'b0;
         next_s.phase = '0;
         next_s.fb_cnt = '0;
         next_s.per_cnt = '0;
      end

      unique case (mode)
         MODE_INTERNAL: next_s.tick = int_tick;
         MODE_DIRECT: next_s.tick = ref_edge;
         MODE_SCALED: next_s.tick = pll_tick;
         MODE_OUTPUT: next_s.tick = int_tick;
      endcase

      // pin driven only in output mode
      next_s.sync_oe = (mode == MODE_OUTPUT);
      if (mode == MODE_OUTPUT && int_tick) begin
         next_s.spulse_cnt = 8'(SYNC_PULSE_CYC - 1);
         next_s.sync_out = 1'b1;
      end else if (s.spulse_cnt != '0) begin
         next_s.spulse_cnt = s.spulse_cnt - 8'd1;
      end else begin
         next_s.sync_out = 1'b0;
      end
      if (mode != MODE_OUTPUT) begin
         next_s.sync_out = 1'b0;
      end

      // One whole sample per tick; long combinational path traded for no pipeline control
      if (next_s.tick) begin
         for (int a = 0; a < 3; a++) begin
            // Full 32-bit square first; a 16-bit product keeps only the low half
            sq = $signed(s.gyro_cal[a]) * $signed(s.gyro_cal[a]);
            gyro_sq[a] = sq[31:16];
         end
         for (int i = 0; i < 3; i++) begin
            wide = mac3(GYRO_SCALE, i, sensor_raw.gyro) +
                   (36'($signed(GYRO_BIAS[i])) <<< CAL_FRAC);
            if (s.cal_rb[MISC_LA_BIT - MISC_RB_LSB]) begin
               wide = wide + mac3(GYRO_LA, i, s.accel_cal);
            end
            gyro_new[i] = sat16(wide >>> CAL_FRAC);
            wide = mac3(ACCEL_SCALE, i, sensor_raw.accel) +
                   (36'($signed(ACCEL_BIAS[i])) <<< CAL_FRAC);
            if (s.cal_rb[MISC_PP_BIT - MISC_RB_LSB]) begin
               wide = wide + mac3(ACCEL_PP, i, gyro_sq);
            end
            accel_new[i] = sat16(wide >>> CAL_FRAC);
         end
         next_s.gyro_cal = gyro_new;
         next_s.accel_cal = accel_new;
         cal6 = {accel_new, gyro_new};
         for (int a = 0; a < 6; a++) begin
            next_s.hist1[a] = {s.hist1[a][6:0], cal6[a]};
            f1 = win_avg(next_s.hist1[a], s.fir[1:0]);
            next_s.hist2[a] = {s.hist2[a][6:0], f1};
            f2 = win_avg(next_s.hist2[a], s.fir[1:0]);
            next_s.acc[a] = s.acc[a] + 32'($signed(f2));
         end
         if (s.dec_cnt >= s.dec) begin
            update = 1'b1;
            next_s.dec_cnt = '0;
            divisor = 33'({1'b0, s.dec}) + 33'sd1;
            for (int a = 0; a < 6; a++) begin
               quot = 33'($signed(next_s.acc[a])) / divisor;
               next_s.out[a] = quot[15:0];
               next_s.acc[a] = '0;
            end
            next_s.data_cnt = s.data_cnt + 16'd1;
         end else begin
            next_s.dec_cnt = s.dec_cnt + 16'd1;
         end
      end

      // data ready pulse on every output update
      if (update) begin
         next_s.dr_cnt = 8'(DR_PULSE_CYC - 1);
         next_s.dr_act = 1'b1;
      end else if (s.dr_cnt != '0) begin
         next_s.dr_cnt = s.dr_cnt - 8'd1;
      end else begin
         next_s.dr_act = 1'b0;
      end
      next_s.dr = next_s.dr_act ~^ s.misc[MISC_POL_BIT];

      // clock settings appear in readback when data ready fires
      if (update && s.cfg_pend) begin
         next_s.mode_rb = s.misc[MISC_MODE_LSB +: 2];
         next_s.scale_rb = s.scale;
         next_s.cfg_pend = 1'b0;
      end

      // delayed readback and take-up of bits 9:6
      if (s.rb_cnt != '0) begin
         next_s.rb_cnt = s.rb_cnt - 17'd1;
         if (s.rb_cnt == 17'd1) begin
            next_s.cal_rb = s.misc[MISC_RB_LSB +: 4];
         end
      end

      // Register writes come last so a new write beats a same-cycle clear
      if (reg_req.wr) begin
         unique case (reg_req.addr)
            ADDR_MISC: begin
               next_s.misc = reg_req.wdata;
               if (reg_req.wdata[MISC_MODE_LSB +: 2] != s.misc[MISC_MODE_LSB +: 2]) begin
                  next_s.cfg_pend = 1'b1;
               end
               next_s.rb_cnt = 17'(RB_DELAY);
            end
            ADDR_SCALE: begin
               next_s.scale = reg_req.wdata;
               if (reg_req.wdata != s.scale) begin
                  next_s.cfg_pend = 1'b1;
               end
            end
            ADDR_FIR: next_s.fir = reg_req.wdata;
            ADDR_DEC: next_s.dec = reg_req.wdata;
            default: ;
         endcase
      end

      // coefficients have no address; unmapped reads return zero
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            ADDR_MISC: next_s.rdata = {s.misc[15:10], s.cal_rb, s.misc[5:4], s.mode_rb,
                                       s.misc[1:0]};
            ADDR_SCALE: next_s.rdata = s.scale_rb;
            ADDR_FIR: next_s.rdata = s.fir;
            ADDR_DEC: next_s.rdata = s.dec;
            ADDR_STATUS: next_s.rdata = {14'h0000, s.cfg_pend, s.locked};
            ADDR_OUT_BASE: next_s.rdata = s.out[0];
            ADDR_OUT_BASE + 8'h01: next_s.rdata = s.out[1];
            ADDR_OUT_BASE + 8'h02: next_s.rdata = s.out[2];
            ADDR_OUT_BASE + 8'h03: next_s.rdata = s.out[3];
            ADDR_OUT_BASE + 8'h04: next_s.rdata = s.out[4];
            ADDR_OUT_BASE + 8'h05: next_s.rdata = s.out[5];
            ADDR_COUNT: next_s.rdata = s.data_cnt;
            default: next_s.rdata = '0;
         endcase
      end
   end

   // ==========================================================
   // State register
   // Reset restores the default internal mode so sampling restarts by itself
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.misc <= MISC_RST;
         s.mode_rb <= MISC_RST[MISC_MODE_LSB +: 2];
         s.cal_rb <= MISC_RST[MISC_RB_LSB +: 4];
         s.scale <= SCALE_RST;
         s.scale_rb <= SCALE_RST;
         s.fir <= FIR_RST;
         s.dec <= DEC_RST;
         s.dr <= ~MISC_RST[MISC_POL_BIT];
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // Outputs, all straight from the state register
   assign reg_rdata = s.rdata;
   assign sample_clock = s.tick;
   assign sync_out = s.sync_out;
   assign sync_oe = s.sync_oe;
   assign data_ready = s.dr;

endmodule : imusc_core

// *** verification/imusc_core_props.sv ***
// Concurrent checks on the ports of the sample clock core.
// Assumes a bind from the bench, one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
module imusc_core_props import imusc_pkg::*; #(
   parameter int INT_DIV = INT_DIV_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input imusc_req_s reg_req,
   input logic [15:0] reg_rdata,
   input logic sample_clock,
   input logic sync_out,
   input logic sync_oe,
   input logic data_ready
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // ==========================================================
   // Helper logic
   logic [31:0] gap;
   logic [15:0] hi_cnt;
   logic seen;
   logic oe_held;
   logic unmapped;
   // Addresses that decode to nothing
   assign unmapped = !(reg_req.addr inside {[8'h00:8'h04], [8'h08:8'h0e]});
   // Sample spacing, sync pulse length, output mode held since last sample
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gap <= 32'h0;
         hi_cnt <= 16'h0;
         seen <= 1'b0;
         oe_held <= 1'b0;
      end else begin
         gap <= sample_clock ? 32'h1 : gap + 32'h1;
         hi_cnt <= sync_out ? hi_cnt + 16'h1 : 16'h0;
         seen <= seen | sample_clock;
         oe_held <= sample_clock ? sync_oe : oe_held & sync_oe;
      end
   end

   // ==========================================================
   // Sequences and properties
   sequence s_sync_lead;
      sync_oe && $rose(sync_out);
   endsequence
   // A polarity write may flip the idle level, so skip edges right after writes
   sequence s_dr_edge;
      $changed(data_ready) && !$past(reg_req.wr) && !$past(reg_req.wr, 2);
   endsequence

   a_reset_quiet:
      assert property ($rose(rst_n) |-> !sync_oe && !data_ready)
      else $error("pin drive or data ready active after reset");
   a_rdata_idle:
      assert property (!$past(reg_req.rd) |-> reg_rdata == 16'h0000)
      else $error("read data outside the answer cycle");
   a_unmapped_zero:
      assert property (reg_req.rd && unmapped |=> reg_rdata == 16'h0000)
      else $error("unmapped read returned data");
   a_sample_single:
      assert property (sample_clock |=> !sample_clock)
      else $error("sample pulse longer than one cycle");
   a_int_period:
      assert property (sample_clock && sync_oe && oe_held && seen |-> gap == INT_DIV)
      else $error("internal sample spacing wrong");
   a_dr_edges:
      assert property (s_dr_edge |-> sample_clock || $past(sample_clock, DR_PULSE_CYC))
      else $error("data ready edge not tied to an update");
   a_sync_align:
      assert property (s_sync_lead |-> sample_clock)
      else $error("sync pulse not aligned to a sample");
   a_sync_len:
      assert property (sync_oe && $fell(sync_out) |-> hi_cnt == SYNC_PULSE_CYC)
      else $error("sync pulse length wrong");
endmodule : imusc_core_props

// *** verification/imusc_sync_src.sv ***
// Behavioural external sync clock source for the sample clock core.
// Assumes the bench sets the half period in ns and starts or stops it.
`timescale 1ns/1ns
module imusc_sync_src (
   input wire logic run,
   input int half_ns,
   output logic level
);
   // ==========================================================
   // Clock generator
   // free clock while enabled, rate scaled up to keep runs short
   initial begin
      level = 1'b0;
      forever begin
         #(half_ns) level = run;
         #(half_ns) level = 1'b0;
      end
   end
endmodule : imusc_sync_src

// *** verification/test_imu_sample_clock_processing.sv ***
// Self-checking bench for the sample clock and processing core.
// Assumes the sync source model and the bound checker sit beside the core.
`timescale 1ns/1ns
module test_imu_sample_clock_processing import imusc_pkg::*; ;
   // Spacing above the 250-cycle pulses so they never overlap
   localparam int DIV = 300;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   imusc_req_s req = '0;
   imusc_raw_s raw = '0;
   logic [15:0] rdata;
   logic smp, sync_in, sync_out, sync_oe, dr, src_lvl;
   logic src_run = 1'b0;
   logic pol = 1'b1;
   int half_ns = 600;
   int num_errors = 0;
   int comparisons = 0;
   int n, d, gk[3], am[3];
   logic [15:0] v, w, cal;

   // ==========================================================
   // Clock, pin and instances
   always #2 sys_clk = ~sys_clk;
   // Pin level from whichever party drives it
   assign sync_in = sync_oe ? sync_out : src_lvl;
   imusc_core #(.INT_DIV(DIV), .LOCK_CYC(20), .RB_DELAY(16)) uut (
      .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata),
      .sensor_raw(raw), .sample_clock(smp), .sync_in(sync_in), .sync_out(sync_out),
      .sync_oe(sync_oe), .data_ready(dr));
   imusc_sync_src src (.run(src_run), .half_ns(half_ns), .level(src_lvl));

   // ==========================================================
   // Tasks
   task automatic end_of_test();
      if (num_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [15:0] dat);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: dat, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] dat);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 dat = rdata;
   endtask : rd
   // Cycles to the next sample, or to the next update when upd is set
   task automatic wait_for(input logic upd, output int cnt);
      cnt = 0;
      do begin
         @(posedge sys_clk);
         #1 cnt++;
         if (cnt > 6000) begin
            check(32'h0, 32'h1);
            end_of_test();
         end
      end while (!(smp === 1'b1 && (!upd || dr === pol)));
   endtask : wait_for
   // Identity scale, zero bias, diagonal and off-diagonal corrections
   function automatic logic [15:0] exp_out(input int i);
      int s;
      if (i < 3) begin
         s = (gk[i] << 12) + (cal[7] ? am[i] : 0);
      end else begin
         s = gk[0] * gk[0] + gk[1] * gk[1] + gk[2] * gk[2] - gk[i - 3] * gk[i - 3];
         s = (am[i - 3] << 8) + (cal[6] ? s : 0);
      end
      return 16'(s);
   endfunction : exp_out

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(87));
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(ADDR_MISC, v);
      check(v, MISC_RST);
      rd(ADDR_SCALE, v);
      check(v, SCALE_RST);
      rd(8'h30, v);
      check(v, 16'h0000);
      src_run <= 1'b1;
      wait_for(1'b0, n);
      wait_for(1'b0, n);
      check(n, DIV);
      check(sync_oe, 1'b0);
      src_run <= 1'b0;
      // Calibration options, filter and decimation with random settings
      for (int c = 0; c < 3; c++) begin
         cal = (c == 1) ? 16'h0080 : (c == 2) ? 16'h0040 : 16'h0000;
         @(posedge sys_clk);
         for (int i = 0; i < 3; i++) begin
            gk[i] = $urandom % 8;
            am[i] = $urandom % 64;
            raw.gyro[i] <= 16'(gk[i] << 12);
            raw.accel[i] <= 16'(am[i] << 8);
         end
         rd(ADDR_MISC, v);
         wr(ADDR_MISC, cal | 16'h0001);
         rd(ADDR_MISC, w);
         check(w, (cal & 16'hfc3f) | (v & 16'h03c0) | 16'h0001);
         wr(ADDR_FIR, 16'($urandom % 4));
         d = $urandom % 3;
         wr(ADDR_DEC, 16'(d));
         repeat (18) wait_for(1'b1, n);
         check(n, (d + 1) * DIV);
         rd(ADDR_MISC, v);
         check(v, cal | 16'h0001);
         for (int i = 0; i < 6; i++) begin
            rd(ADDR_OUT_BASE + 8'(i), v);
            check(v, exp_out(i));
         end
      end
      wr(ADDR_DEC, 16'h0000);
      wr(ADDR_MISC, 16'h0000);
      pol = 1'b0;
      wait_for(1'b1, n);
      repeat (260) @(posedge sys_clk);
      check(dr, 1'b1);
      wr(ADDR_FIR, 16'h0001);
      @(posedge sys_clk);
      raw.gyro[0] <= 16'h0400;
      wait_for(1'b1, n);
      rd(ADDR_OUT_BASE, v);
      check(v, (((gk[0] << 12) + 1024) / 2 + (gk[0] << 12)) / 2);
      // Output sync mode and delayed mode readback
      wr(ADDR_MISC, 16'h000c);
      rd(ADDR_MISC, v);
      check(v, 16'h0000);
      wait_for(1'b1, n);
      rd(ADDR_MISC, v);
      check(v, 16'h000c);
      check(sync_oe, 1'b1);
      wait_for(1'b0, n);
      wait_for(1'b0, n);
      check(n, DIV);
      repeat (260) @(posedge sys_clk);
      wr(ADDR_MISC, 16'h0000);
      wait_for(1'b1, n);
      wait_for(1'b1, n);
      check(sync_oe, 1'b0);
      // Direct input sync
      half_ns <= 700;
      src_run <= 1'b1;
      wr(ADDR_MISC, 16'h0004);
      repeat (4) wait_for(1'b0, n);
      check(n, 350);
      // Scaled sync, lock, then loss of lock on a factor change
      // factor sent as one word
      wr(ADDR_SCALE, 16'h0002);
      half_ns <= 2000;
      wr(ADDR_MISC, 16'h0008);
      repeat (12) wait_for(1'b0, n);
      check(n inside {[499:501]}, 1'b1);
      rd(ADDR_STATUS, v);
      check(v[0], 1'b1);
      rd(ADDR_SCALE, v);
      check(v, 16'h0002);
      wr(ADDR_SCALE, 16'h0003);
      rd(ADDR_STATUS, v);
      check(v[0], 1'b0);
      rd(ADDR_SCALE, v);
      check(v, 16'h0002);
      end_of_test();
   end
endmodule : test_imu_sample_clock_processing

bind imusc_core imusc_core_props #(.INT_DIV(INT_DIV)) chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
   .sample_clock(sample_clock), .sync_out(sync_out), .sync_oe(sync_oe),
   .data_ready(data_ready));
